// ### mpwm_core.sv
// Motor PWM configuration slice: APB registers, special event trigger,
// duty/override update timing, pin enables and dead-time pairs.
// Assumes the time base count, direction and boundary pulse come from
// logic on core_clk_i; the power-on config bit is a static external level.
// Functional notes
// - Period holds 15 bits, top bit reads zero
// - Trigger when compare equals count and direction matches
// - Direction bit one fires counting down only
// - Pair mode one independent, zero complementary
// - High pin enable routes PWM, else GPIO
// - Low pin enable routes PWM, else GPIO
// - Pin enable reset from power-on config bit
// - Trigger postscaler divides by field plus one
// - Immediate bit: duty writes act one cycle after the write
// - Override sync bit: overrides at time-base boundary
// - Update disable blocks duty and period buffer to active transfers, not override
// - Unit B prescale gives 1,2,4,8 cycles
// - Unit B six-bit count in bits 13-8
// - Unit A prescale gives 1,2,4,8 cycles
// - Unit A six-bit count in bits 5-0
// - Small instance drives only one pair
// - Unimplemented bits ignore writes, read zero
// - Direction status and count readable
// - Override bit zero selects manual output
module mpwm_core
	import mpwm_pkg::*;
#(
	parameter int PAIR_COUNT = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [14:0] time_base_count_i,
	input wire logic count_direction_status_i,
	input wire logic tb_boundary_i,
	input wire logic pin_enable_reset_config_i,
	output logic [14:0] active_period_o,
	output logic special_event_trigger_o,
	output mpwm_pins_t pwm_pins_o
);
	// Software-visible registers
	logic [15:0] time_base_period; // Period buffer
	logic [15:0] special_event_compare; // Direction and compare value
	logic [15:0] pair_mode_and_pin_enable; // Mode and pin enables
	logic [15:0] trigger_postscale_and_update_control; // Postscale and update bits
	logic [15:0] dead_time_units_setup; // Dead-time units A and B
	logic [15:0] output_override_register; // Override select and manual bits
	logic [15:0] duty_cycle_registers [PAIRS_MAX]; // Duty buffers
	// Active copies
	logic [15:0] active_duty [PAIRS_MAX]; // Duty in use by the comparators
	logic [15:0] active_override; // Override in use at the pins
	// Config sync, trigger and pair-mask support
	logic cfg_meta; // Config bit synchroniser stage one
	logic cfg_sync; // Config bit synchroniser stage two
	logic [3:0] post_cnt; // Trigger postscale counter
	logic match_q; // Previous compare match
	logic [2:0] pair_mask; // Pairs present in this instance
	// Decoded control
	logic wr_en; // Write access phase
	logic rd_en; // Read access phase
	logic addr_ok; // Address mapped
	logic [7:0] addr; // Low address byte
	logic [15:0] wdat; // Write data low half
	logic [3:0] post_sel; // Postscale field
	logic immediate_duty_update; // Immediate duty update
	logic override_sync_select; // Override synchronised
	logic buffer_update_disable; // Buffer update disable
	logic match; // Compare hit this cycle
	logic [2:0] mode_ind; // Independent pair bits
	logic [2:0] hen; // High pin enables
	logic [2:0] len; // Low pin enables
	// Per-pair datapath, bit index is pair minus one
	logic [2:0] raw_hi; // Comparator outputs
	logic [2:0] dt_hi; // After dead time
	logic [2:0] dt_lo; // After dead time
	// Override fields split per pin
	logic [2:0] ovd_sel; // Generator selected, high side
	logic [2:0] ovd_sel_l; // Generator selected, low side
	logic [2:0] man_hi; // Manual high values
	logic [2:0] man_lo; // Manual low values
	// Divider limits, cycles per tick minus one
	logic [2:0] limit_a; // Unit A divider limit
	logic [2:0] limit_b; // Unit B divider limit

	// Absent pairs never drive, and store no duty, mode or enable bits
	assign pair_mask = (PAIR_COUNT >= PAIRS_MAX) ? 3'h7 : 3'h1;
	// Only the low address byte selects a register
	assign addr = paddr[7:0];
	assign wdat = pwdata[15:0];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	// Every register answers in the first access cycle
	assign pready = 1'b1; // Zero wait states
	// Control bits decoded once, by name
	assign post_sel = trigger_postscale_and_update_control[CON2_POST_LSB +: 4];
	assign immediate_duty_update = trigger_postscale_and_update_control[CON2_IUE_BIT];
	assign override_sync_select = trigger_postscale_and_update_control[CON2_OVERRIDE_SYNC_SELECT_BIT];
	assign buffer_update_disable = trigger_postscale_and_update_control[CON2_BUFFER_UPDATE_DISABLE_BIT];
	// Pair mode and pin routing fields
	assign mode_ind = pair_mode_and_pin_enable[CON1_MODE_LSB +: 3];
	assign hen = pair_mode_and_pin_enable[CON1_HEN_LSB +: 3];
	assign len = pair_mode_and_pin_enable[CON1_LEN_LSB +: 3];
	// Prescale codes 00..11 map to 1,2,4,8 cycles, stored as cycles minus one
	// Shift form keeps the divider a 3-bit compare
	assign limit_a = 3'((4'h1 << dead_time_units_setup[DT_APS_LSB +: 2]) - 4'h1);
	assign limit_b = 3'((4'h1 << dead_time_units_setup[DT_BPS_LSB +: 2]) - 4'h1);

	// Address decode for APB slave error
	// Nonzero upper address bits are refused
	always_comb begin
		case (addr)
			ADDR_PERIOD, ADDR_SECMP, ADDR_CON1, ADDR_CON2, ADDR_DTCON1,
			ADDR_TBSTAT, ADDR_OVD, ADDR_DUTY1, ADDR_DUTY2, ADDR_DUTY3: begin
				addr_ok = (paddr[31:8] == 24'h000000);
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end
	assign pslverr = psel && penable && !addr_ok;

	// Two flip-flops on the static config bit; no reset so reset can load it
	// Valid two edges in, so reset must last longer
	always_ff @(posedge core_clk_i) begin
		cfg_meta <= pin_enable_reset_config_i;
		cfg_sync <= cfg_meta;
	end

	// Period buffer, low 15 bits only
	// Bit 15 is dropped so it reads back zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			time_base_period <= RST_ZERO;
		end else if (wr_en && addr == ADDR_PERIOD && addr_ok) begin
			time_base_period <= wdat & MASK_PERIOD;
		end
	end

	// Special event compare with direction select
	// Bit 15 direction, bits 14-0 compare value
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			special_event_compare <= RST_ZERO;
		end else if (wr_en && addr == ADDR_SECMP && addr_ok) begin
			special_event_compare <= wdat & MASK_SECMP;
		end
	end

	// Mode and pin enables; enables reset from the config bit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			// Small instance keeps pair 1 enables only
			pair_mode_and_pin_enable <= {9'h000, {3{cfg_sync}}, 1'b0, {3{cfg_sync}}}
				& {9'h000, pair_mask, 1'b0, pair_mask};
		end else if (wr_en && addr == ADDR_CON1 && addr_ok) begin
			// Bits of absent pairs stay zero
			pair_mode_and_pin_enable <= wdat & MASK_CON1
				& {5'h00, pair_mask, 1'b0, pair_mask, 1'b0, pair_mask};
		end
	end

	// Postscale and update control
	// Unused bits masked so they read zero
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			trigger_postscale_and_update_control <= RST_ZERO;
		end else if (wr_en && addr == ADDR_CON2 && addr_ok) begin
			trigger_postscale_and_update_control <= wdat & MASK_CON2;
		end
	end

	// Dead-time units A and B
	// All sixteen bits are implemented
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dead_time_units_setup <= RST_ZERO;
		end else if (wr_en && addr == ADDR_DTCON1 && addr_ok) begin
			dead_time_units_setup <= wdat & MASK_DTCON1;
		end
	end

	// Override register, generator selected after reset
	// Field order per pair is high then low
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			output_override_register <= RST_OVD;
		end else if (wr_en && addr == ADDR_OVD && addr_ok) begin
			output_override_register <= wdat & MASK_OVD;
		end
	end

	// Duty buffers, full 16 bits
	// Absent pairs ignore writes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < PAIRS_MAX; i++) begin
				duty_cycle_registers[i] <= RST_ZERO;
			end
		end else if (wr_en && addr_ok) begin
			if (addr == ADDR_DUTY1) begin
				duty_cycle_registers[0] <= wdat;
			end
			if (addr == ADDR_DUTY2 && pair_mask[1]) begin
				duty_cycle_registers[1] <= wdat;
			end
			if (addr == ADDR_DUTY3 && pair_mask[2]) begin
				duty_cycle_registers[2] <= wdat;
			end
		end
	end

	// Active duty and period; transfers are blocked while update disable is set.
	// Immediate mode copies one cycle after the write so the bus path stays short.
	// Limitation: update disable freezes immediate mode too.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			active_period_o <= 15'h0000;
			for (int i = 0; i < PAIRS_MAX; i++) begin
				active_duty[i] <= RST_ZERO;
			end
		end else if (!buffer_update_disable) begin
			if (tb_boundary_i) begin
				active_period_o <= time_base_period[14:0];
			end
			if (tb_boundary_i || immediate_duty_update) begin
				for (int i = 0; i < PAIRS_MAX; i++) begin
					active_duty[i] <= duty_cycle_registers[i];
				end
			end
		end
	end

	// Override copy: at boundary when synchronised, else next cycle
	// Unsynchronised copy lags the write by one cycle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			active_override <= RST_OVD;
		end else if (!override_sync_select || tb_boundary_i) begin
			active_override <= output_override_register;
		end
	end

	// Compare hit needs value and direction; direction one means counting down
	// Count and direction share this clock, no sync
	assign match = (special_event_compare[14:0] == time_base_count_i)
		&& (special_event_compare[SECMP_DIR_BIT] == count_direction_status_i);

	// Rising edge of the hit so a stalled count gives one event
	// Cleared in reset so the first hit is seen
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	// Postscaler: one trigger every post_sel plus one hits
	// Count survives postscale changes; set it first
	// Greater-or-equal lets a smaller setting fire at once
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			post_cnt <= 4'h0;
			special_event_trigger_o <= 1'b0;
		end else begin
			special_event_trigger_o <= 1'b0;
			if (match && !match_q) begin
				if (post_cnt >= post_sel) begin
					post_cnt <= 4'h0;
					special_event_trigger_o <= 1'b1;
				end else begin
					post_cnt <= post_cnt + 4'h1;
				end
			end
		end
	end

	// Comparators and dead time per pair
	// High while the duty value exceeds the count
	// Unit A times high turn-on, unit B low turn-on
	for (genvar p = 0; p < PAIRS_MAX; p++) begin : g_pair
		assign raw_hi[p] = active_duty[p][14:0] > time_base_count_i;
		mpwm_deadtime u_dt (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.independent_i(mode_ind[p]),
			.high_raw_i(raw_hi[p]),
			.low_raw_i(raw_hi[p]),
			.on_high_count_i(dead_time_units_setup[DT_A_LSB +: 6]),
			.on_high_limit_i(limit_a),
			.on_low_count_i(dead_time_units_setup[DT_B_LSB +: 6]),
			.on_low_limit_i(limit_b),
			.high_o(dt_hi[p]),
			.low_o(dt_lo[p])
		);
		// Override selects for this pair sit high then low
		assign ovd_sel[p] = active_override[OVD_SEL_LSB + 2 * p + 1];
		assign ovd_sel_l[p] = active_override[OVD_SEL_LSB + 2 * p];
		assign man_hi[p] = active_override[OVD_OUT_LSB + 2 * p + 1];
		assign man_lo[p] = active_override[OVD_OUT_LSB + 2 * p];
	end

	// Pin drive: override, then enable; disabled pins are released low
	// Registered so gate drivers see clean levels
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pwm_pins_o <= '0;
		end else begin
			pwm_pins_o.high <= hen & pair_mask
				& ((ovd_sel & dt_hi) | (~ovd_sel & man_hi));
			pwm_pins_o.low <= len & pair_mask
				& ((ovd_sel_l & dt_lo) | (~ovd_sel_l & man_lo));
			pwm_pins_o.high_en <= hen & pair_mask;
			pwm_pins_o.low_en <= len & pair_mask;
		end
	end

	// Read mux; unimplemented bits are zero because registers store masked data
	// Reads have no side effects; status is live
	always_comb begin
		prdata = 32'h00000000;
		if (rd_en && addr_ok) begin
			case (addr)
				ADDR_PERIOD: prdata[15:0] = time_base_period;
				ADDR_SECMP: prdata[15:0] = special_event_compare;
				ADDR_CON1: prdata[15:0] = pair_mode_and_pin_enable;
				ADDR_CON2: prdata[15:0] = trigger_postscale_and_update_control;
				ADDR_DTCON1: prdata[15:0] = dead_time_units_setup;
				ADDR_TBSTAT: prdata[15:0] = {count_direction_status_i, time_base_count_i};
				ADDR_OVD: prdata[15:0] = output_override_register;
				ADDR_DUTY1: prdata[15:0] = duty_cycle_registers[0];
				ADDR_DUTY2: prdata[15:0] = duty_cycle_registers[1];
				ADDR_DUTY3: prdata[15:0] = duty_cycle_registers[2];
				default: prdata = 32'h00000000;
			endcase
		end
	end

endmodule : mpwm_core

// ### mpwm_pkg.sv
// Package for the motor PWM slice: register map, field layout, reset values.
// Assumes a 32-bit APB bus with 16-bit registers in the low half of each word.
package mpwm_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_PERIOD = 8'h00;
	localparam logic [7:0] ADDR_SECMP = 8'h04;
	localparam logic [7:0] ADDR_CON1 = 8'h08;
	localparam logic [7:0] ADDR_CON2 = 8'h0C;
	localparam logic [7:0] ADDR_DTCON1 = 8'h10;
	localparam logic [7:0] ADDR_TBSTAT = 8'h14;
	localparam logic [7:0] ADDR_OVD = 8'h18;
	localparam logic [7:0] ADDR_DUTY1 = 8'h1C;
	localparam logic [7:0] ADDR_DUTY2 = 8'h20;
	localparam logic [7:0] ADDR_DUTY3 = 8'h24;
	// Writable bit masks, unimplemented bits are zero
	localparam logic [15:0] MASK_PERIOD = 16'h7FFF;
	localparam logic [15:0] MASK_SECMP = 16'hFFFF;
	localparam logic [15:0] MASK_CON1 = 16'h0777;
	localparam logic [15:0] MASK_CON2 = 16'h0F07;
	localparam logic [15:0] MASK_DTCON1 = 16'hFFFF;
	localparam logic [15:0] MASK_OVD = 16'h3F3F;
	// Reset values
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_OVD = 16'h3F00;
	// Field positions
	localparam int SECMP_DIR_BIT = 15;
	localparam int CON1_MODE_LSB = 8;
	localparam int CON1_HEN_LSB = 4;
	localparam int CON1_LEN_LSB = 0;
	localparam int CON2_POST_LSB = 8;
	localparam int CON2_IUE_BIT = 2;
	localparam int CON2_OVERRIDE_SYNC_SELECT_BIT = 1;
	localparam int CON2_BUFFER_UPDATE_DISABLE_BIT = 0;
	localparam int DT_BPS_LSB = 14;
	localparam int DT_B_LSB = 8;
	localparam int DT_APS_LSB = 6;
	localparam int DT_A_LSB = 0;
	localparam int OVD_SEL_LSB = 8;
	localparam int OVD_OUT_LSB = 0;
	localparam int TBSTAT_DIR_BIT = 15;
	// Sizes
	localparam int PAIRS_MAX = 3;
	localparam int CNT_W = 15;
	// Output group for the switch pairs
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
		logic [2:0] high_en;
		logic [2:0] low_en;
	} mpwm_pins_t;
endpackage : mpwm_pkg

// ### mpwm_deadtime.sv
// Dead-time inserter for one output pair.
// Assumes same-clock raw PWM levels; prescale limits are cycles per tick minus one.
module mpwm_deadtime (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic independent_i,
	input wire logic high_raw_i,
	input wire logic low_raw_i,
	input wire logic [5:0] on_high_count_i,
	input wire logic [2:0] on_high_limit_i,
	input wire logic [5:0] on_low_count_i,
	input wire logic [2:0] on_low_limit_i,
	output logic high_o,
	output logic low_o
);
	logic prev_raw; // Last raw level seen, tracked in both modes
	logic waiting; // Dead time running
	logic [5:0] dead_cnt; // Remaining dead-time ticks
	logic [2:0] pre_cnt; // Prescale divider
	logic [2:0] limit; // Divider limit of the unit in use

	// High turning on uses unit A, low turning on uses unit B
	assign limit = prev_raw ? on_high_limit_i : on_low_limit_i;

	// Turn-off is immediate, turn-on waits count times prescaled period
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			prev_raw <= 1'b0;
			waiting <= 1'b1;
			dead_cnt <= 6'h00;
			pre_cnt <= 3'h0;
			high_o <= 1'b0;
			low_o <= 1'b0;
		end else if (independent_i) begin
			// Independent pair, no dead time
			high_o <= high_raw_i;
			low_o <= low_raw_i;
			prev_raw <= high_raw_i;
			waiting <= 1'b0;
		end else if (high_raw_i != prev_raw) begin
			// Edge: both off, start the dead interval
			prev_raw <= high_raw_i;
			high_o <= 1'b0;
			low_o <= 1'b0;
			waiting <= 1'b1;
			pre_cnt <= 3'h0;
			dead_cnt <= high_raw_i ? on_high_count_i : on_low_count_i;
		end else if (waiting) begin
			if (dead_cnt == 6'h00) begin
				// Dead time over, complement restored
				high_o <= prev_raw;
				low_o <= ~prev_raw;
				waiting <= 1'b0;
			end else if (pre_cnt == limit) begin
				pre_cnt <= 3'h0;
				dead_cnt <= dead_cnt - 6'h01;
			end else begin
				pre_cnt <= pre_cnt + 3'h1;
			end
		end else begin
			// Steady complementary levels
			high_o <= prev_raw;
			low_o <= ~prev_raw;
		end
	end
endmodule : mpwm_deadtime

// ### mpwm_core_properties.sv
// Property checker for mpwm_core, bound onto every instance at the foot.
// Assumes single clock; shadows the registers it needs from APB writes.
module mpwm_core_properties
	import mpwm_pkg::*;
#(
	parameter int PAIR_COUNT = 3
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [14:0] time_base_count_i,
	input wire logic count_direction_status_i,
	input wire logic tb_boundary_i,
	input wire logic [14:0] active_period_o,
	input wire logic special_event_trigger_o,
	input wire mpwm_pins_t pwm_pins_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic acc; // Access phase
	logic match; // Compare hit this cycle
	logic match_q; // Hit one cycle ago
	logic [15:0] secmp;
	logic [15:0] con1;
	logic [15:0] con2;
	logic [15:0] ovd;
	logic [5:0] en_mask; // Small instance keeps pair 1 only
	assign acc = psel && penable;
	assign en_mask = (PAIR_COUNT == 1) ? 6'h09 : 6'h3F;
	assign match = secmp[14:0] == time_base_count_i && secmp[15] == count_direction_status_i;
	// Shadows follow writes at the same edge the block takes them
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			secmp <= 16'h0000;
			con1 <= 16'h0000;
			con2 <= 16'h0000;
			ovd <= RST_OVD;
		end else if (acc && pwrite) begin
			if (paddr[7:0] == ADDR_SECMP) begin
				secmp <= pwdata[15:0];
			end
			if (paddr[7:0] == ADDR_CON1) begin
				con1 <= pwdata[15:0];
			end
			if (paddr[7:0] == ADDR_CON2) begin
				con2 <= pwdata[15:0];
			end
			if (paddr[7:0] == ADDR_OVD) begin
				ovd <= pwdata[15:0];
			end
		end
	end
	// Edge detector for compare hits; only rising hits count
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end
	sequence s_rd(logic [7:0] a);
		acc && !pwrite && paddr[7:0] == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		acc && pwrite && paddr[7:0] == a;
	endsequence
	sequence s_hit;
		match && !match_q;
	endsequence
	chk_period_msb: assert property (s_rd(ADDR_PERIOD) |-> prdata[31:15] == 17'h0)
		else $error("period top bit not zero");
	chk_status_read: assert property (s_rd(ADDR_TBSTAT) |->
		prdata[15:0] == {count_direction_status_i, time_base_count_i})
		else $error("status read wrong");
	chk_trig_cause: assert property (special_event_trigger_o |-> $past(match && !match_q))
		else $error("trigger without compare hit");
	chk_trig_every: assert property (s_hit ##0 con2[11:8] == 4'h0 |=> special_event_trigger_o)
		else $error("trigger missed at postscale one");
	chk_pin_enable: assert property (s_wr(ADDR_CON1) |-> ##2
		{pwm_pins_o.high_en, pwm_pins_o.low_en} == ($past({pwdata[6:4], pwdata[2:0]}, 2) & en_mask))
		else $error("pin enables do not follow write");
	chk_gpio_level: assert property ((pwm_pins_o.high & ~pwm_pins_o.high_en) == 3'h0 &&
		(pwm_pins_o.low & ~pwm_pins_o.low_en) == 3'h0)
		else $error("released pin driven");
	chk_period_sync: assert property ($changed(active_period_o) |->
		$past(tb_boundary_i && !con2[0]))
		else $error("period moved off boundary");
	chk_no_overlap: assert property (!con1[8] && !$past(con1[8], 4) && ovd[9:8] == 2'h3 &&
		$past(ovd[9:8], 4) == 2'h3 |-> !(pwm_pins_o.high[0] && pwm_pins_o.low[0]))
		else $error("complementary pair both on");
	chk_con_zero: assert property (s_rd(ADDR_CON1) |-> (prdata[15:0] & ~MASK_CON1) == 16'h0)
		else $error("unimplemented control bits set");
endmodule : mpwm_core_properties

bind mpwm_core mpwm_core_properties #(.PAIR_COUNT(PAIR_COUNT)) props (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .time_base_count_i(time_base_count_i),
	.count_direction_status_i(count_direction_status_i), .tb_boundary_i(tb_boundary_i),
	.active_period_o(active_period_o), .special_event_trigger_o(special_event_trigger_o),
	.pwm_pins_o(pwm_pins_o));

// ### mpwm_gate_model.sv
// Gate driver model for the switch pairs fed by the pin group.
// Assumes pins registered on core_clk_i; records any both-gates-on cycle.
module mpwm_gate_model
	import mpwm_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic clear_i,
	input wire mpwm_pins_t pins_i,
	output logic [2:0] shoot_o
);
	logic [2:0] gate_h; // Released pin leaves gate off
	logic [2:0] gate_l;
	assign gate_h = pins_i.high & pins_i.high_en;
	assign gate_l = pins_i.low & pins_i.low_en;
	// Sticky overlap record; a real stage would short the rail here
	always_ff @(posedge core_clk_i) begin
		if (clear_i) begin
			shoot_o <= 3'h0;
		end else begin
			shoot_o <= shoot_o | (gate_h & gate_l);
		end
	end
endmodule : mpwm_gate_model

// ### tb_top.sv
// Bench for mpwm_core: registers, trigger, pins, dead time, update timing.
// Assumes a 50 MHz clock; the bench plays the time base itself.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mpwm_pkg::*;
	logic core_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, trig, dir = 1'b0, bnd = 1'b0, clr = 1'b1, cfg = 1'b1;
	logic [14:0] tcnt = 15'h7FFF, aper; // Idle count never matches
	logic [2:0] shoot;
	mpwm_pins_t pins;
	int fails = 0, check_count = 0, trig_n = 0;
	mpwm_core #(.PAIR_COUNT(3)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .time_base_count_i(tcnt),
		.count_direction_status_i(dir), .tb_boundary_i(bnd), .pin_enable_reset_config_i(cfg),
		.active_period_o(aper), .special_event_trigger_o(trig), .pwm_pins_o(pins));
	mpwm_gate_model gates (.core_clk_i(core_clk_i), .clear_i(clr), .pins_i(pins), .shoot_o(shoot));
	// Core clock
	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	// Trigger tally
	always @(posedge core_clk_i) begin
		if (trig === 1'b1) begin
			trig_n++;
		end
	end
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	// One transfer; request held until pready seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {16'h0, d};
		@(posedge core_clk_i);
		penable <= 1'b1;
		@(posedge core_clk_i);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge core_clk_i);
			n++;
		end
		fails += (n == 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 16'h0);
		chk(s, rd, e);
	endtask : rdc
	// Each pass gives one rising compare hit when d matches the compare direction
	task automatic edges(input int n, input logic d);
		repeat (n) begin
			tcnt <= 15'h0010;
			dir <= d;
			@(posedge core_clk_i);
			tcnt <= 15'h0011;
			@(posedge core_clk_i);
		end
		tcnt <= 15'h7FFF;
		dir <= 1'b0;
		@(posedge core_clk_i);
	endtask : edges
	task automatic pulse();
		bnd <= 1'b1;
		@(posedge core_clk_i);
		bnd <= 1'b0;
		repeat (4) @(posedge core_clk_i);
	endtask : pulse
	// Cycles from the off pin falling to the on pin rising
	task automatic gap(input logic hi, input int exp);
		int n;
		n = 0;
		wr(ADDR_DUTY1, {15'h0, hi});
		while ((hi ? pins.low[0] : pins.high[0]) !== 1'b0 && n < 99) begin
			@(posedge core_clk_i);
			n++;
		end
		n = 0;
		while ((hi ? pins.high[0] : pins.low[0]) !== 1'b1 && n < 600) begin
			@(posedge core_clk_i);
			n++;
		end
		chk("dead time", n, exp);
	endtask : gap
	task automatic t_regs();
		logic [7:0] ad [6] = '{ADDR_PERIOD, ADDR_SECMP, ADDR_CON1, ADDR_CON2, ADDR_DTCON1, ADDR_OVD};
		logic [15:0] rv [6] = '{RST_ZERO, RST_ZERO, 16'h0077, RST_ZERO, RST_ZERO, RST_OVD};
		logic [15:0] mk [6] = '{MASK_PERIOD, MASK_SECMP, MASK_CON1, MASK_CON2, MASK_DTCON1, MASK_OVD};
		chk("pin enables", 32'({pins.high_en, pins.low_en}), 32'h3F);
		for (int i = 0; i < 6; i++) begin
			rdc("reset value", ad[i], {16'h0, rv[i]});
			wr(ad[i], 16'hFFFF);
			rdc("masked write", ad[i], {16'h0, mk[i]});
			wr(ad[i], rv[i]);
		end
		dir <= 1'b1;
		rdc("status", ADDR_TBSTAT, 32'hFFFF);
		dir <= 1'b0;
		apb(1'b0, 8'h28, 16'h0);
		chk("unmapped error", 32'(err), 32'h1);
	endtask : t_regs
	// Both directions, several postscales, wrong-direction hits ignored
	task automatic t_trigger();
		int post [4] = '{0, 1, 3, 15};
		int t0;
		for (int dv = 0; dv < 2; dv++) begin
			wr(ADDR_SECMP, {dv[0], 15'h0010});
			foreach (post[i]) begin
				wr(ADDR_CON2, 16'(post[i] << 8));
				t0 = trig_n;
				edges(2 * (post[i] + 1), dv[0]);
				edges(3, !dv[0]);
				repeat (3) @(posedge core_clk_i);
				chk("trigger count", trig_n - t0, 2);
			end
		end
	endtask : t_trigger
	task automatic t_dead();
		clr <= 1'b0;
		tcnt <= 15'h0000;
		wr(ADDR_CON1, 16'h0077);
		wr(ADDR_CON2, 16'h0004);
		for (int ps = 0; ps < 4; ps++) begin
			wr(ADDR_DTCON1, 16'(ps << 14) | 16'h3F00 | 16'(ps << 6) | 16'h0003);
			gap(1'b1, 3 * (1 << ps) + 1);
			gap(1'b0, 63 * (1 << ps) + 1);
		end
		chk("overlap", 32'(shoot), 32'h0);
	endtask : t_dead
	task automatic t_pair();
		wr(ADDR_CON2, 16'h0000);
		wr(ADDR_CON1, 16'h0177);
		wr(ADDR_DUTY1, 16'h0001);
		repeat (6) @(posedge core_clk_i);
		chk("duty held", 32'({pins.high[0], pins.low[0]}), 32'h0);
		pulse();
		chk("independent", 32'({pins.high[0], pins.low[0]}), 32'h3);
		wr(ADDR_OVD, 16'h3E00);
		repeat (3) @(posedge core_clk_i);
		chk("manual low", 32'({pins.high[0], pins.low[0]}), 32'h2);
		wr(ADDR_CON2, 16'h0002);
		wr(ADDR_OVD, RST_OVD);
		repeat (3) @(posedge core_clk_i);
		chk("override held", 32'({pins.high[0], pins.low[0]}), 32'h2);
		pulse();
		chk("override synced", 32'({pins.high[0], pins.low[0]}), 32'h3);
		wr(ADDR_CON1, 16'h0100);
		repeat (3) @(posedge core_clk_i);
		chk("released pins", 32'(pins), 32'h0);
	endtask : t_pair
	task automatic t_period();
		wr(ADDR_CON2, 16'h0001);
		wr(ADDR_PERIOD, 16'hF234);
		pulse();
		chk("period frozen", 32'(aper), 32'h0);
		wr(ADDR_CON2, 16'h0000);
		repeat (3) @(posedge core_clk_i);
		chk("period waits", 32'(aper), 32'h0);
		pulse();
		chk("period loaded", 32'(aper), 32'h7234);
	endtask : t_period
	// Mid-run reset with the config bit low: enables come up released
	task automatic t_reset();
		cfg <= 1'b0;
		rst_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		chk("enables after reset", 32'({pins.high_en, pins.low_en}), 32'h0);
		rdc("config reset", ADDR_CON1, 32'h0);
	endtask : t_reset
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		t_regs();
		t_trigger();
		t_dead();
		t_pair();
		t_period();
		t_reset();
		report_and_stop();
	end
	// Watchdog, well beyond the expected few thousand cycles
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end
endmodule : tb_top
